/* File: logic/sci_pkg.sv */
package sci_pkg;
   // crc control field of the command register
   typedef enum logic [1:0]
   {
      CRC_NOP = 2'h0,
      CRC_RX_INIT = 2'h1,
      CRC_TX_INIT = 2'h2,
      CRC_CLR_EOM = 2'h3
   } sci_crc_cmd_t;

   // channel command field of the command register
   typedef enum logic [2:0]
   {
      CMD_NOP = 3'h0,
      CMD_HIGH_PTR = 3'h1,
      CMD_RST_ES = 3'h2,
      CMD_CHAN_RST = 3'h3,
      CMD_EN_NEXT_RX = 3'h4,
      CMD_RST_TX_PEND = 3'h5,
      CMD_ERR_RST = 3'h6,
      CMD_EOI = 3'h7
   } sci_chan_cmd_t;

   // command register fields
   localparam int CR0_CRC_LO = 6;
   localparam int CR0_CMD_LO = 3;
   localparam int CR0_PTR_LO = 0;

   // interrupt_enable_mode fields
   localparam int CR1_SHORT_EN = 7;
   localparam int CR1_OVR_IMM = 6;
   localparam int CR1_FIRST_MASK = 5;
   localparam int CR1_RXMODE_LO = 3;
   localparam int CR1_FIRST_TX = 2;
   localparam int CR1_TX_EN = 1;
   localparam int CR1_ES_EN = 0;
   localparam logic [1:0] RXM_OFF = 2'h0;
   localparam logic [1:0] RXM_FIRST = 2'h1;
   localparam logic [1:0] RXM_ALL_PAR = 2'h2;
   localparam logic [1:0] RXM_ALL = 2'h3;

   // vector_priority_transfer_mode fields
   localparam int CR2_VEC_EN = 7;
   localparam int CR2_SAV = 6;
   localparam int CR2_VMODE_LO = 3;
   localparam int CR2_PRIO = 2;
   localparam int CR2_XFER_LO = 0;
   localparam logic [1:0] XFER_INT = 2'h0;
   localparam logic [1:0] XFER_DMA_A = 2'h1;
   localparam logic [1:0] XFER_DMA_AB = 2'h2;
   localparam logic [2:0] VMODE_B1 = 3'h3;
   localparam logic [2:0] VMODE_B2 = 3'h4;

   // register numbers behind the control address
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_INT_EN = 4'h1;
   localparam logic [3:0] REG_VEC = 4'h2;
   localparam logic [3:0] SR_MAIN = 4'h0;
   localparam logic [3:0] SR_ES = 4'h1;
   localparam logic [3:0] SR_VECT = 4'h2;

   // special receive condition bits, main status d7..d3 as [4:0]
   localparam int SP_SHORT = 0;
   localparam int SP_PARITY = 1;
   localparam int SP_OVERRUN = 2;

   // interrupt sources in request order and cause codes
   localparam int NUM_SRC = 6;
   localparam logic [2:0] LVL_NONE = 3'h7;
   localparam logic [1:0] CAUSE_TX = 2'h0;
   localparam logic [1:0] CAUSE_ES = 2'h1;
   localparam logic [1:0] CAUSE_RX = 2'h2;
   localparam logic [1:0] CAUSE_SPECIAL = 2'h3;

   // resets and timing
   localparam logic [7:0] CR1_RESET = 8'h00;
   localparam logic [7:0] CR2_RESET = 8'h00;
   localparam int MIN_FRAME_BITS = 32;
   localparam int RESET_HOLD_CLOCKS = 3;
   localparam logic [1:0] RESET_HOLD = 2'(RESET_HOLD_CLOCKS);
endpackage

/* File: logic/sci_cr0_dec.sv */
module sci_cr0_dec
(
   // written command byte
   input wire logic [7:0] i_byte,
   // decoded fields
   output sci_pkg::sci_crc_cmd_t o_crc,
   output sci_pkg::sci_chan_cmd_t o_cmd,
   output logic [2:0] o_ptr
);
   import sci_pkg::*;

   // all three fields come from one write and act together
   assign o_crc = sci_crc_cmd_t'(i_byte[CR0_CRC_LO +: 2]);
   assign o_cmd = sci_chan_cmd_t'(i_byte[CR0_CMD_LO +: 3]);
   assign o_ptr = i_byte[CR0_PTR_LO +: 3];
endmodule

/* File: logic/sci_int_prio.sv */
module sci_int_prio
(
   // requests: rx a, tx a, rx b, tx b, status a, status b
   input wire logic [5:0] i_req,
   input wire logic i_prio_sel,
   input wire logic i_special_a,
   // vector configuration
   input wire logic [7:0] i_base,
   input wire logic i_sav,
   input wire logic [2:0] i_vmode,
   // winner
   output logic o_valid,
   output logic [2:0] o_level,
   output logic [7:0] o_vector
);
   import sci_pkg::*;

   function automatic logic [2:0] src_at(input logic [2:0] rank, input logic sel);
      logic [2:0] r;
      r = rank;
      if (sel && rank == 3'h1)
         r = 3'h2;
      else if (sel && rank == 3'h2)
         r = 3'h1;
      return r;
   endfunction

   logic [2:0] src;
   logic [2:0] cause;

   always_comb
   begin
      o_valid = 1'b0;
      o_level = LVL_NONE;
      src = 3'h0;
      for (int k = NUM_SRC - 1; k >= 0; k--)
      begin
         if (i_req[src_at(3'(k), i_prio_sel)])
         begin
            o_valid = 1'b1;
            o_level = 3'(k);
            src = src_at(3'(k), i_prio_sel);
         end
      end
   end

   always_comb
   begin
      unique case (src)
         3'h0: cause = {1'b0, i_special_a ? CAUSE_SPECIAL : CAUSE_RX};
         3'h1: cause = {1'b0, CAUSE_TX};
         3'h2: cause = {1'b1, CAUSE_RX};
         3'h3: cause = {1'b1, CAUSE_TX};
         3'h4: cause = {1'b0, CAUSE_ES};
         default: cause = {1'b1, CAUSE_ES};
      endcase
      o_vector = i_base;
      if (i_sav && o_valid)
      begin
         if (i_vmode == VMODE_B1 || i_vmode == VMODE_B2)
            o_vector[2:0] = cause;
         else
            o_vector[4:2] = cause;
      end
   end
endmodule

/* File: logic/sci_chan_ctrl.sv */
// Behaviour
// - crc field, sync modes only: nop, rx init, tx init, clear underrun flag.
// - bit-sync mode re-initialises receive crc on each received flag.
// - underrun sends crc when flag is 0, sync or flag when 1.
// - flag set when crc or sync loaded; bit-sync first data write clears it.
// - three-bit channel command decodes eight commands.
// - high pointer plus pointer selects registers 8 to 15.
// - pointer returns to zero on reset and after each following access.
// - reset-status command reopens status latches; new status hidden until then.
// - channel reset acts like reset pin; host waits three clocks.
// - enable-next-receive arms one first-byte interrupt, only unmasked first mode.
// - reset-transmit-pending clears transmit request while buffer empty.
// - error reset clears special bits; first mode holds data until then.
// - end of interrupt clears in-service latch, host issues after each service.
// - bit-sync short frame under 32 bits sets status, special interrupt.
// - overrun flagged at last stage, or immediately when timing bit set.
// - receive interrupt modes off, first, all with parity, all without parity.
// - transmit request on full-to-empty, and on enable when first bit set.
// - status change latches bits and interrupts once until latches reset.
// - vectored enable drives vector on acknowledge, else read releases interrupt.
// - status-affects-vector puts cause into vector bits chosen by mode.
// - two fixed priority orders chosen by priority bit, in every transfer mode.
// - dma channel suppresses transmit interrupts; others stay available.
// - transfer mode 00 interrupts, 01 dma on a, 10 dma both.
module sci_chan_ctrl
#(
   parameter int FRAME_LEN_W = 16
)
(
   // system
   input wire logic i_clock,
   input wire logic i_srst,
   // host port
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_cd,
   input wire logic [7:0] i_wdata,
   input wire logic i_int_acknowledge_cycle,
   input wire logic [7:0] i_vector_base,
   output logic [7:0] o_rdata,
   output logic o_data_oe_n,
   output logic o_int,
   output logic o_drq_tx,
   // protocol configuration
   input wire logic i_char_sync_mode,
   input wire logic i_bit_sync_mode,
   input wire logic i_crc_init_one,
   // transmitter
   input wire logic i_tx_enable,
   input wire logic i_tx_buf_full,
   input wire logic i_tx_last_bit,
   input wire logic i_tx_crc_loaded,
   output logic o_tx_crc_init,
   output logic o_tx_underrun,
   output logic o_tx_send_crc,
   // receiver
   input wire logic i_rx_flag,
   input wire logic i_rx_byte,
   input wire logic i_parity_err,
   input wire logic i_overrun_now,
   input wire logic i_overrun_last,
   input wire logic i_frame_end,
   input wire logic [FRAME_LEN_W-1:0] i_frame_len,
   output logic o_rx_crc_init,
   output logic o_crc_init_value,
   output logic o_rx_hold,
   // external status
   input wire logic i_es_change,
   input wire logic [7:0] i_es_status,
   // channel b requests
   input wire logic i_b_rx_req,
   input wire logic i_b_tx_req,
   input wire logic i_b_es_req,
   // channel reset
   output logic o_chan_reset
);
   import sci_pkg::*;

   typedef struct packed {
      logic [2:0] ptr;
      logic hi;
      logic [7:0] cr1;
      logic [7:0] cr2;
      logic es_open;
      logic es_pend;
      logic [7:0] es_reg;
      logic end_of_message;
      logic tx_pend;
      logic rx_pend;
      logic rx_armed;
      logic [4:0] special;
      logic [2:0] srv_level;
      logic [1:0] rst_cnt;
      logic tx_full_d;
      logic tx_en_d;
      logic rx_crc_init;
      logic tx_crc_init;
      logic underrun;
      logic send_crc;
      logic drive;
      logic [7:0] rdata;
   } sci_state_t;

   localparam sci_state_t ST_RESET = '{
      cr1: CR1_RESET,
      cr2: CR2_RESET,
      es_open: 1'b1,
      rx_armed: 1'b1,
      srv_level: LVL_NONE,
      default: '0
   };

   sci_state_t s;
   sci_state_t next_s;
   sci_crc_cmd_t crc_cmd;
   sci_chan_cmd_t chan_cmd;
   logic [2:0] cmd_ptr;
   logic [5:0] req;
   logic prio_valid;
   logic [2:0] prio_level;
   logic [7:0] vector;
   logic int_now;
   logic [1:0] rx_mode;
   logic a_dma;
   logic b_dma;

   sci_cr0_dec u_dec
   (
      .i_byte(i_wdata),
      .o_crc(crc_cmd),
      .o_cmd(chan_cmd),
      .o_ptr(cmd_ptr)
   );

   assign rx_mode = s.cr1[CR1_RXMODE_LO +: 2];
   assign a_dma = s.cr2[CR2_XFER_LO +: 2] == XFER_DMA_A || s.cr2[CR2_XFER_LO +: 2] == XFER_DMA_AB;
   assign b_dma = s.cr2[CR2_XFER_LO +: 2] == XFER_DMA_AB;

   assign req[0] = s.rx_pend | (|s.special);
   assign req[1] = s.tx_pend & ~a_dma;
   assign req[2] = i_b_rx_req;
   assign req[3] = i_b_tx_req & ~b_dma;
   assign req[4] = s.es_pend;
   assign req[5] = i_b_es_req;

   sci_int_prio u_prio
   (
      .i_req(req),
      .i_prio_sel(s.cr2[CR2_PRIO]),
      .i_special_a(|s.special),
      .i_base(i_vector_base),
      .i_sav(s.cr2[CR2_SAV]),
      .i_vmode(s.cr2[CR2_VMODE_LO +: 3]),
      .o_valid(prio_valid),
      .o_level(prio_level),
      .o_vector(vector)
   );

   // only requests above the one in service
   assign int_now = prio_valid && prio_level < s.srv_level;

   always_comb
   begin
      logic busy;
      logic ctl_wr;
      logic ctl_rd;
      logic chan_rst;
      logic [3:0] sel;
      logic tx_event;
      busy = s.rst_cnt != 2'h0;
      // writes during the reset hold are dropped
      ctl_wr = i_wr & i_cd & ~busy;
      ctl_rd = i_rd & i_cd;
      chan_rst = 1'b0;
      sel = {s.hi, s.ptr};
      tx_event = 1'b0;
      next_s = s;
      next_s.rx_crc_init = 1'b0;
      next_s.tx_crc_init = 1'b0;
      next_s.underrun = 1'b0;
      next_s.drive = 1'b0;
      if (busy)
         next_s.rst_cnt = s.rst_cnt - 2'h1;

      if (ctl_wr && sel == REG_CMD)
      begin
         next_s.ptr = cmd_ptr;
         next_s.hi = chan_cmd == CMD_HIGH_PTR;
         if (i_char_sync_mode || i_bit_sync_mode)
         begin
            unique case (crc_cmd)
               CRC_NOP: ;
               CRC_RX_INIT: next_s.rx_crc_init = 1'b1;
               CRC_TX_INIT: next_s.tx_crc_init = 1'b1;
               CRC_CLR_EOM: next_s.end_of_message = 1'b0;
            endcase
         end
         unique case (chan_cmd)
            CMD_NOP, CMD_HIGH_PTR: ;
            CMD_RST_ES:
            begin
               next_s.es_open = 1'b1;
               next_s.es_pend = 1'b0;
            end
            CMD_CHAN_RST: chan_rst = 1'b1;
            CMD_EN_NEXT_RX:
            begin
               if (rx_mode == RXM_FIRST && !s.cr1[CR1_FIRST_MASK])
                  next_s.rx_armed = 1'b1;
            end
            CMD_RST_TX_PEND:
            begin
               if (!i_tx_buf_full)
                  next_s.tx_pend = 1'b0;
            end
            CMD_ERR_RST: next_s.special = 5'h00;
            CMD_EOI: next_s.srv_level = LVL_NONE;
         endcase
      end
      else if (ctl_wr)
      begin
         if (sel == REG_INT_EN)
            next_s.cr1 = i_wdata;
         if (sel == REG_VEC)
            next_s.cr2 = i_wdata;
         next_s.ptr = 3'h0;
         next_s.hi = 1'b0;
      end

      if (ctl_rd)
      begin
         next_s.drive = 1'b1;
         next_s.ptr = 3'h0;
         next_s.hi = 1'b0;
         unique case (sel)
            SR_MAIN: next_s.rdata = {s.special, ~i_tx_buf_full, int_now, s.rx_pend};
            SR_ES: next_s.rdata = s.es_reg;
            SR_VECT:
            begin
               next_s.rdata = vector;
               if (prio_valid && prio_level < s.srv_level)
                  next_s.srv_level = prio_level;
            end
            default: next_s.rdata = 8'h00;
         endcase
      end

      if (i_int_acknowledge_cycle && int_now)
      begin
         next_s.srv_level = prio_level;
         if (s.cr2[CR2_VEC_EN])
         begin
            next_s.drive = 1'b1;
            next_s.rdata = vector;
         end
      end

      // data path writes and reads clear the byte requests
      if (i_wr && !i_cd && !busy)
      begin
         next_s.tx_pend = 1'b0;
         if (i_bit_sync_mode && s.end_of_message)
            next_s.end_of_message = 1'b0;
      end
      if (i_rd && !i_cd)
         next_s.rx_pend = 1'b0;

      // hardware sets come after host clears so the set wins
      // underrun choice
      if (i_tx_last_bit && !i_tx_buf_full)
      begin
         next_s.underrun = 1'b1;
         next_s.send_crc = ~s.end_of_message;
      end
      // set on crc or sync load
      if (i_tx_crc_loaded)
         next_s.end_of_message = 1'b1;
      if (i_bit_sync_mode && i_rx_flag)
         next_s.rx_crc_init = 1'b1;

      next_s.tx_full_d = i_tx_buf_full;
      next_s.tx_en_d = i_tx_enable;
      tx_event = (s.tx_full_d & ~i_tx_buf_full) | (i_tx_enable & ~s.tx_en_d & s.cr1[CR1_FIRST_TX]);
      if (s.cr1[CR1_TX_EN] && tx_event)
         next_s.tx_pend = 1'b1;

      if (i_rx_byte)
      begin
         unique case (rx_mode)
            RXM_OFF: ;
            RXM_FIRST:
            begin
               // mask hides the first byte but keeps the arming consumed
               if (s.rx_armed)
               begin
                  next_s.rx_armed = 1'b0;
                  if (!s.cr1[CR1_FIRST_MASK])
                     next_s.rx_pend = 1'b1;
               end
            end
            RXM_ALL_PAR, RXM_ALL: next_s.rx_pend = 1'b1;
         endcase
      end
      // parity special only in mode 10
      if (i_parity_err && rx_mode == RXM_ALL_PAR)
         next_s.special[SP_PARITY] = 1'b1;
      if (s.cr1[CR1_OVR_IMM] ? i_overrun_now : i_overrun_last)
         next_s.special[SP_OVERRUN] = 1'b1;
      if (i_bit_sync_mode && s.cr1[CR1_SHORT_EN] && i_frame_end &&
          i_frame_len < FRAME_LEN_W'(MIN_FRAME_BITS))
         next_s.special[SP_SHORT] = 1'b1;

      if (next_s.es_open)
      begin
         next_s.es_reg = i_es_status;
         if (s.cr1[CR1_ES_EN] && i_es_change)
         begin
            next_s.es_open = 1'b0;
            next_s.es_pend = 1'b1;
         end
      end

      if (chan_rst)
      begin
         next_s = ST_RESET;
         next_s.rst_cnt = RESET_HOLD;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         s <= ST_RESET;
      else
         s <= next_s;
   end

   assign o_rdata = s.rdata;
   // low while the vector or a status byte is on the bus
   assign o_data_oe_n = ~s.drive;
   assign o_int = int_now;
   assign o_drq_tx = s.tx_pend & a_dma;
   assign o_tx_crc_init = s.tx_crc_init;
   assign o_tx_underrun = s.underrun;
   assign o_tx_send_crc = s.send_crc;
   assign o_rx_crc_init = s.rx_crc_init;
   assign o_crc_init_value = i_crc_init_one;
   // hold receive data in first mode while special bits are set
   assign o_rx_hold = rx_mode == RXM_FIRST && s.special != 5'h00;
   assign o_chan_reset = s.rst_cnt != 2'h0;
endmodule

/* File: tb/sci_host_model.sv */
module sci_host_model
(
   // clock
   input wire logic i_clock,
   // host bus
   output logic o_wr,
   output logic o_rd,
   output logic o_cd,
   output logic [7:0] o_wdata,
   output logic o_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   // set only by a scenario that breaks the settle time on purpose
   logic rude = 1'b0;
   initial
   begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_cd = 1'b0;
      o_wdata = 8'h00;
      o_ack = 1'b0;
   end
   task automatic xfer(input logic w, input logic cd, input logic [7:0] d);
      @(negedge i_clock);
      o_wr = w;
      o_rd = !w;
      o_cd = cd;
      o_wdata = d;
      @(negedge i_clock);
      o_wr = 1'b0;
      o_rd = 1'b0;
      // released bus shows no stale byte
      o_wdata = ~d;
      if (w && cd && d[5:3] == 3'h3 && !rude)
         repeat (3) @(negedge i_clock);
   endtask
   task automatic ack();
      @(negedge i_clock);
      o_ack = 1'b1;
      @(negedge i_clock);
      o_ack = 1'b0;
   endtask
endmodule

/* File: tb/sci_chan_ctrl_asserts.sv */
module sci_chan_ctrl_asserts
(
   // watched ports
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_cd,
   input wire logic [7:0] i_wdata,
   input wire logic i_int_acknowledge_cycle,
   input wire logic [7:0] i_vector_base,
   input wire logic i_char_sync_mode,
   input wire logic i_bit_sync_mode,
   input wire logic i_rx_flag,
   input wire logic i_tx_last_bit,
   input wire logic i_tx_buf_full,
   input wire logic [7:0] o_rdata,
   input wire logic o_data_oe_n,
   input wire logic o_int,
   input wire logic o_tx_crc_init,
   input wire logic o_rx_crc_init,
   input wire logic o_tx_underrun,
   input wire logic o_chan_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   import sci_pkg::*;
   logic ptr_set;
   logic [2:0] ptr;
   logic [7:0] cr2;
   logic cmd_wr;
   logic sync;
   assign sync = i_char_sync_mode | i_bit_sync_mode;
   // writes refused during channel reset are not commands
   assign cmd_wr = i_wr & i_cd & !ptr_set & !o_chan_reset;
   always_ff @(posedge i_clock)
   begin
      if (i_srst || (cmd_wr && i_wdata[5:3] == CMD_CHAN_RST))
      begin
         ptr_set <= 1'b0;
         cr2 <= 8'h00;
      end
      else if (i_wr && i_cd && !o_chan_reset)
      begin
         ptr_set <= !ptr_set && i_wdata[2:0] != 3'h0;
         ptr <= i_wdata[2:0];
         if (ptr_set && ptr == 3'h2)
            cr2 <= i_wdata;
      end
      else if (i_rd && i_cd)
         ptr_set <= 1'b0;
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_srst);
   property p_crc_tx;
      cmd_wr && sync && i_wdata[7:6] == CRC_TX_INIT |=> o_tx_crc_init;
   endproperty
   a_crc_tx: assert property (p_crc_tx) else $error("tx crc init missing");
   property p_crc_rx;
      cmd_wr && sync && i_wdata[7:6] == CRC_RX_INIT |=> o_rx_crc_init;
   endproperty
   a_crc_rx: assert property (p_crc_rx) else $error("rx crc init missing");
   property p_crc_async;
      cmd_wr && !sync |=> !o_tx_crc_init && !o_rx_crc_init;
   endproperty
   a_crc_async: assert property (p_crc_async) else $error("crc init outside sync");
   property p_flag_init;
      i_bit_sync_mode && i_rx_flag |=> o_rx_crc_init;
   endproperty
   a_flag_init: assert property (p_flag_init) else $error("no init on flag");
   property p_chan_rst;
      cmd_wr && i_wdata[5:3] == CMD_CHAN_RST |=> o_chan_reset [*3] ##1 !o_chan_reset;
   endproperty
   a_chan_rst: assert property (p_chan_rst) else $error("channel reset length");
   property p_refuse;
      o_chan_reset && i_wr && i_cd |=> !o_tx_crc_init;
   endproperty
   a_refuse: assert property (p_refuse) else $error("write taken in reset");
   property p_underrun;
      i_tx_last_bit && !i_tx_buf_full && sync && !o_chan_reset |=> o_tx_underrun;
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun missing");
   property p_vec_drive;
      i_int_acknowledge_cycle && o_int && cr2[7] |=> !o_data_oe_n;
   endproperty
   a_vec_drive: assert property (p_vec_drive) else $error("vector not driven");
   property p_vec_plain;
      i_int_acknowledge_cycle && o_int && cr2[7:6] == 2'h2 |=> o_rdata == $past(i_vector_base);
   endproperty
   a_vec_plain: assert property (p_vec_plain) else $error("vector modified");
   c_ack: cover property (i_int_acknowledge_cycle && o_int);
   c_rst: cover property (o_chan_reset);
   c_urun: cover property (o_tx_underrun);
endmodule
bind sci_chan_ctrl sci_chan_ctrl_asserts sci_chan_ctrl_asserts_i (.i_clock, .i_srst, .i_wr, .i_rd,
   .i_cd, .i_wdata, .i_int_acknowledge_cycle, .i_vector_base, .i_char_sync_mode, .i_bit_sync_mode,
   .i_rx_flag, .i_tx_last_bit, .i_tx_buf_full, .o_rdata, .o_data_oe_n, .o_int, .o_tx_crc_init,
   .o_rx_crc_init, .o_tx_underrun, .o_chan_reset);

/* File: tb/sci_chan_ctrl_tb_top.sv */
module sci_chan_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sci_pkg::*;
   logic i_clock = 0, i_srst = 1, i_char_sync_mode = 0, i_bit_sync_mode = 0, i_crc_init_one = 0;
   logic i_tx_enable = 0, i_tx_buf_full = 0, i_tx_last_bit = 0, i_tx_crc_loaded = 0, i_rx_flag = 0;
   logic i_rx_byte = 0, i_es_change = 0, i_b_rx_req = 0, i_b_tx_req = 0, i_b_es_req = 0;
   logic i_parity_err = 0, i_overrun_now = 0, i_overrun_last = 0, i_frame_end = 0;
   logic [15:0] i_frame_len = 0;
   logic [7:0] i_vector_base = 0, i_es_status = 0, s1;
   logic h_wr, h_rd, h_cd, h_ack, o_data_oe_n, o_int, o_drq_tx, o_tx_crc_init, o_tx_underrun;
   logic o_tx_send_crc, o_rx_crc_init, o_crc_init_value, o_rx_hold, o_chan_reset;
   logic [7:0] h_wd, o_rdata;
   logic [7:0] cr2v [4] = '{8'h80, 8'hc0, 8'hd8, 8'h00};
   int seed = 32'h4eb98ab3;
   int n_tests = 0, n_mismatch = 0, t = 0;
   sci_host_model sci_host_model_i (.i_clock, .o_wr(h_wr), .o_rd(h_rd), .o_cd(h_cd), .o_wdata(h_wd),
      .o_ack(h_ack));
   sci_chan_ctrl sci_chan_ctrl_i (.i_clock, .i_srst, .i_wr(h_wr), .i_rd(h_rd), .i_cd(h_cd),
      .i_wdata(h_wd), .i_int_acknowledge_cycle(h_ack), .i_vector_base, .o_rdata, .o_data_oe_n, .o_int,
      .o_drq_tx, .i_char_sync_mode, .i_bit_sync_mode, .i_crc_init_one, .i_tx_enable, .i_tx_buf_full,
      .i_tx_last_bit, .i_tx_crc_loaded, .o_tx_crc_init, .o_tx_underrun, .o_tx_send_crc, .i_rx_flag,
      .i_rx_byte, .i_parity_err, .i_overrun_now, .i_overrun_last, .i_frame_end,
      .i_frame_len, .o_rx_crc_init, .o_crc_init_value, .o_rx_hold, .i_es_change, .i_es_status,
      .i_b_rx_req, .i_b_tx_req, .i_b_es_req, .o_chan_reset);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      sci_host_model_i.xfer(1'b1, 1'b1, d);
   endtask
   task automatic rd();
      sci_host_model_i.xfer(1'b0, 1'b1, 8'h00);
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clock);
      s = 1'b1;
      @(negedge i_clock);
      s = 1'b0;
   endtask
   task automatic rst();
      i_srst = 1'b1;
      repeat (2) @(negedge i_clock);
      i_srst = 1'b0;
   endtask
   task automatic done();
      t++;
      $display("test %0d done, mismatches %0d", t, n_mismatch);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // expected vector: rx on channel a has cause code 3'h2
   function automatic logic [7:0] vexp(input logic [7:0] b, input logic [7:0] c2);
      if (!c2[CR2_SAV])
         return b;
      if (c2[5:3] == VMODE_B1 || c2[5:3] == VMODE_B2)
         return {b[7:3], 3'h2};
      return {b[7:5], 3'h2, b[1:0]};
   endfunction
   initial
   begin
      forever #5 i_clock = ~i_clock;
   end
   initial
   begin
      #300000;
      n_mismatch++;
      stop_test();
   end
   initial
   begin
      i_crc_init_one = 1'($random(seed));
      repeat (8) @(negedge i_clock);
      i_srst = 1'b0;
      i_char_sync_mode = 1'b1;
      wr(8'h81);
      flag(o_tx_crc_init, 1'b1);
      wr(8'h10);
      wr(8'h09);
      wr(8'h00);
      wr(8'h0b);
      rd();
      chk(o_rdata, 8'h00);
      flag(o_data_oe_n, 1'b0);
      rd();
      chk(o_rdata, 8'h04);
      pulse(i_rx_byte);
      flag(o_int, 1'b1);
      done();
      for (int m = 0; m < 3; m++)
         for (int c = 0; c < 4; c++)
         begin
            rst();
            i_char_sync_mode = (m == 1);
            i_bit_sync_mode = (m == 2);
            wr(8'(c << 6));
            flag(o_rx_crc_init, m > 0 && c == 1);
            flag(o_tx_crc_init, m > 0 && c == 2);
         end
      pulse(i_rx_flag);
      flag(o_rx_crc_init, 1'b1);
      flag(o_crc_init_value, i_crc_init_one);
      done();
      rst();
      i_bit_sync_mode = 1'b0;
      i_char_sync_mode = 1'b1;
      wr(8'h01);
      wr(8'h10);
      sci_host_model_i.rude = 1'b1;
      wr(8'h18);
      flag(o_chan_reset, 1'b1);
      wr(8'h80);
      flag(o_tx_crc_init, 1'b0);
      sci_host_model_i.rude = 1'b0;
      repeat (3) @(negedge i_clock);
      pulse(i_rx_byte);
      flag(o_int, 1'b0);
      wr(8'h80);
      flag(o_tx_crc_init, 1'b1);
      done();
      foreach (cr2v[k])
      begin
         rst();
         {i_b_rx_req, i_b_tx_req, i_b_es_req} = 3'h0;
         i_vector_base = 8'($random(seed));
         wr(8'h01);
         wr(8'h10);
         wr(8'h02);
         wr(cr2v[k]);
         sci_host_model_i.ack();
         flag(o_data_oe_n, 1'b1);
         pulse(i_rx_byte);
         flag(o_int, 1'b1);
         if (cr2v[k][7])
            sci_host_model_i.ack();
         else
         begin
            wr(8'h02);
            rd();
         end
         chk(o_rdata, vexp(i_vector_base, cr2v[k]));
         flag(o_data_oe_n, 1'b0);
         flag(o_int, 1'b0);
         {i_b_rx_req, i_b_tx_req, i_b_es_req} = 3'h7;
         sci_host_model_i.xfer(1'b0, 1'b0, 8'h00);
         flag(o_int, 1'b0);
         wr(8'h38);
         flag(o_int, 1'b1);
      end
      {i_b_rx_req, i_b_tx_req, i_b_es_req} = 3'h0;
      done();
      for (int m = 0; m < 2; m++)
      begin
         rst();
         i_char_sync_mode = (m == 0);
         i_bit_sync_mode = (m == 1);
         pulse(i_tx_crc_loaded);
         pulse(i_tx_last_bit);
         flag(o_tx_underrun, 1'b1);
         flag(o_tx_send_crc, 1'b0);
         if (m == 1)
            sci_host_model_i.xfer(1'b1, 1'b0, 8'h55);
         else
            wr(8'hc0);
         pulse(i_tx_last_bit);
         flag(o_tx_send_crc, 1'b1);
      end
      done();
      rst();
      wr(8'h01);
      wr(8'h01);
      s1 = 8'($random(seed));
      i_es_status = s1;
      pulse(i_es_change);
      flag(o_int, 1'b1);
      i_es_status = ~s1;
      pulse(i_es_change);
      wr(8'h01);
      rd();
      chk(o_rdata, s1);
      wr(8'h10);
      pulse(i_es_change);
      wr(8'h01);
      rd();
      chk(o_rdata, ~s1);
      done();
      rst();
      wr(8'h01);
      wr(8'h06);
      i_tx_enable = 1'b1;
      @(negedge i_clock);
      flag(o_int, 1'b1);
      wr(8'h28);
      flag(o_int, 1'b0);
      pulse(i_tx_buf_full);
      @(negedge i_clock);
      flag(o_int, 1'b1);
      i_tx_enable = 1'b0;
      rst();
      wr(8'h02);
      wr(8'h01);
      wr(8'h01);
      wr(8'h06);
      i_tx_enable = 1'b1;
      @(negedge i_clock);
      flag(o_drq_tx, 1'b1);
      flag(o_int, 1'b0);
      done();
      rst();
      wr(8'h01);
      wr(8'h88);
      i_frame_len = 16'h0020;
      pulse(i_frame_end);
      flag(o_int, 1'b0);
      i_frame_len = 16'h001f;
      pulse(i_frame_end);
      flag(o_rx_hold, 1'b1);
      flag(o_int, 1'b1);
      wr(8'h30);
      flag(o_rx_hold, 1'b0);
      pulse(i_parity_err);
      pulse(i_overrun_now);
      flag(o_int, 1'b0);
      pulse(i_overrun_last);
      flag(o_int, 1'b1);
      wr(8'h30);
      pulse(i_rx_byte);
      flag(o_int, 1'b1);
      sci_host_model_i.xfer(1'b0, 1'b0, 8'h00);
      pulse(i_rx_byte);
      flag(o_int, 1'b0);
      wr(8'h20);
      pulse(i_rx_byte);
      flag(o_int, 1'b1);
      done();
      stop_test();
   end
endmodule
